// ### nps_pkg.sv
// Constants and types shared by the negate-and-store datapath
package nps_pkg;
  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int unsigned DATA_W = 32;
  localparam int unsigned EXP_W = 8;
  localparam int unsigned XREG_W = 40;
  localparam int unsigned AXI_AW = 8;
  localparam int unsigned CORE_N = 16;

  // ----------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_INSTR = 8'h04;
  localparam logic [7:0] ADDR_FLAGS = 8'h08;
  localparam logic [7:0] ADDR_REG_SEL = 8'h0C;
  localparam logic [7:0] ADDR_REG_LO = 8'h10;
  localparam logic [7:0] ADDR_REG_HI = 8'h14;
  localparam logic [7:0] ADDR_MEM_ADDR = 8'h18;
  localparam logic [7:0] ADDR_MEM_DATA = 8'h1C;
  localparam logic [7:0] ADDR_IRQ_STAT = 8'h20;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h24;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam int unsigned BUSY_BIT = 8;
  localparam int unsigned IRQ_W = 3;
  localparam int unsigned IRQ_DONE = 0;
  localparam int unsigned IRQ_OVF = 1;
  localparam int unsigned IRQ_UNF = 2;
  localparam logic [IRQ_W-1:0] IRQ_MASK_RST = 3'h0;

  // ----------------------------------------------------------------
  // Instruction word fields
  // ----------------------------------------------------------------
  localparam int unsigned F_OP = 30;
  localparam int unsigned F_MODE = 28;
  localparam int unsigned F_DST = 24;
  localparam int unsigned F_SRC3 = 21;
  localparam int unsigned F_AR1 = 19;
  localparam int unsigned F_DSP1 = 17;
  localparam int unsigned F_AR2 = 15;
  localparam int unsigned F_DSP2 = 13;
  localparam int unsigned F_IMM = 0;
  localparam logic [1:0] OP_FNEG_STORE = 2'h1;
  localparam logic [1:0] OP_INEG = 2'h2;
  localparam logic [1:0] MODE_REG = 2'h0;
  localparam logic [1:0] MODE_DIRECT = 2'h1;
  localparam logic [1:0] MODE_INDIRECT = 2'h2;
  localparam logic [1:0] MODE_IMM = 2'h3;
  localparam logic [1:0] DISP_ZERO = 2'h0;
  localparam logic [1:0] DISP_ONE = 2'h1;
  localparam logic [1:0] DISP_IREG0 = 2'h2;
  localparam logic [1:0] DISP_IREG1 = 2'h3;
  localparam logic [1:0] IDX_AR_HI = 2'h2;
  localparam logic [3:0] IDX_IREG0 = 4'hC;
  localparam logic [3:0] IDX_IREG1 = 4'hD;

  // ----------------------------------------------------------------
  // Number formats
  // ----------------------------------------------------------------
  localparam logic [EXP_W-1:0] EXP_ZERO = 8'h80;
  localparam logic [EXP_W-1:0] EXP_MIN = 8'h81;
  localparam logic [EXP_W-1:0] EXP_MAX = 8'h7F;
  localparam logic [DATA_W-1:0] MAN_POS_MAX = 32'h7FFF_FFFF;
  localparam logic [DATA_W-1:0] INT_MIN = 32'h8000_0000;
  localparam logic [DATA_W-1:0] INT_POS_MAX = 32'h7FFF_FFFF;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {ST_IDLE, ST_FETCH, ST_EXEC} nps_state_e;

  typedef struct packed {
    logic sticky_unf;
    logic sticky_ovf;
    logic unf;
    logic n;
    logic z;
    logic v;
    logic c;
  } nps_flags_s;

  localparam nps_flags_s FLAGS_RST = 7'h00;

  typedef struct packed {
    logic awvalid;
    logic [AXI_AW-1:0] awaddr;
    logic wvalid;
    logic [DATA_W-1:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [AXI_AW-1:0] araddr;
    logic rready;
  } nps_axi_req_s;

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [DATA_W-1:0] rdata;
    logic [1:0] rresp;
  } nps_axi_rsp_s;
endpackage : nps_pkg

// ### nps_mem.sv
// Data memory with one write port and a registered read port
`timescale 1ns/1ns
module nps_mem #(
  parameter int unsigned AW = 8,
  parameter int unsigned DW = 32
) (
  input wire logic clk,
  input wire logic we,
  input wire logic [AW-1:0] waddr,
  input wire logic [DW-1:0] wdata,
  input wire logic [AW-1:0] raddr,
  output logic [DW-1:0] rdata_r
);
  logic [DW-1:0] mem_r [2**AW];

  // Read before write: a colliding read sees the old word
  always_ff @(posedge clk) begin
    rdata_r <= mem_r[raddr];
    if (we) begin
      mem_r[waddr] <= wdata;
    end
  end
endmodule : nps_mem

// ### nps_neg.sv
// Floating-point and integer negators, purely combinational
`timescale 1ns/1ns
module nps_neg (
  input wire logic [nps_pkg::EXP_W-1:0] f_exp,
  input wire logic [nps_pkg::DATA_W-1:0] f_man,
  input wire logic [nps_pkg::DATA_W-1:0] i_src,
  input wire logic sat_mode,
  output logic [nps_pkg::EXP_W-1:0] f_res_exp,
  output logic [nps_pkg::DATA_W-1:0] f_res_man,
  output logic f_ovf,
  output logic f_unf,
  output logic [nps_pkg::DATA_W-1:0] i_res,
  output logic i_ovf,
  output logic i_borrow
);
  import nps_pkg::*;

  logic frac_zero;
  logic [DATA_W:0] i_diff;

  assign frac_zero = (f_man[30:0] == 31'h0000_0000);

  // Only +1.0 and -2.0 mantissas change exponent when negated
  always_comb begin
    f_res_exp = f_exp;
    f_res_man = {~f_man[31], -f_man[30:0]};
    f_ovf = 1'b0;
    f_unf = 1'b0;
    if (f_exp == EXP_ZERO) begin
      f_res_man = '0;
    end else if (frac_zero && !f_man[31]) begin
      f_res_man = INT_MIN;
      f_res_exp = f_exp - 8'h01;
      if (f_exp == EXP_MIN) begin
        f_unf = 1'b1;
        f_res_exp = EXP_ZERO;
        f_res_man = '0;
      end
    end else if (frac_zero) begin
      f_res_man = '0;
      f_res_exp = f_exp + 8'h01;
      if (f_exp == EXP_MAX) begin
        f_ovf = 1'b1;
        f_res_exp = EXP_MAX;
        f_res_man = MAN_POS_MAX;
      end
    end
  end

  assign i_diff = 33'h0_0000_0000 - {1'b0, i_src};
  assign i_borrow = i_diff[DATA_W];
  assign i_ovf = (i_src == INT_MIN);
  assign i_res = (i_ovf && sat_mode) ? INT_POS_MAX : i_diff[DATA_W-1:0];
endmodule : nps_neg

// ### nps_top.sv
// Negate datapath with parallel float store, AXI4-Lite register slave
//
// Function
// - Float op negates src2, stores src3 in parallel
// - Indirect operands, displacement 0, 1, index regs; R0-R7
// - Operands read before commit; store sees old
// - Flags change only for destinations R0-R7
// - Float underflow sets sticky underflow, else kept
// - Float overflow sets sticky overflow, else kept
// - Float underflow flag follows underflow, else cleared
// - Negative and zero flags follow result
// - Float overflow flag follows overflow; carry kept
// - Float pair ignores saturation mode
// - Integer negate is signed zero minus source
// - Integer source mode: register, direct, indirect, immediate
// - Integer keeps sticky underflow; overflow sets sticky
// - Integer overflow flag follows; underflow cleared
// - Integer carry set on borrow
// - Integer result depends on saturation mode
`timescale 1ns/1ns
module nps_top #(
  parameter int unsigned MEM_AW = 8
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire nps_pkg::nps_axi_req_s s_axi_req,
  output nps_pkg::nps_axi_rsp_s s_axi_rsp,
  output logic irq
);
  import nps_pkg::*;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  nps_state_e state_r;
  logic [DATA_W-1:0] instr_r;
  logic [XREG_W-1:0] core_r [CORE_N];
  nps_flags_s flags_r;
  nps_flags_s flags_nxt;
  logic sat_mode_r;
  logic [3:0] regsel_r;
  logic [MEM_AW-1:0] mem_addr_r;
  logic [IRQ_W-1:0] irq_stat_r;
  logic [IRQ_W-1:0] irq_mask_r;
  logic [AXI_AW-1:0] awaddr_r;
  logic [DATA_W-1:0] wdata_r;
  logic [3:0] wstrb_r;
  nps_axi_rsp_s rsp_r;

  assign s_axi_rsp = rsp_r;

  // ----------------------------------------------------------------
  // Instruction decode
  // ----------------------------------------------------------------
  logic [1:0] op;
  logic [1:0] mode;
  logic [3:0] dst_idx;
  logic [3:0] src3_idx;
  logic [15:0] imm;
  logic exec;
  logic exec_f;
  logic exec_i;
  logic dst_is_ext;
  logic [DATA_W-1:0] ea1;
  logic [DATA_W-1:0] ea2;

  assign op = instr_r[F_OP +: 2];
  assign mode = instr_r[F_MODE +: 2];
  assign imm = instr_r[F_IMM +: 16];
  assign src3_idx = {1'b0, instr_r[F_SRC3 +: 3]};
  assign dst_idx = (op == OP_FNEG_STORE) ? {1'b0, instr_r[F_DST +: 3]} : instr_r[F_DST +: 4];
  assign dst_is_ext = !dst_idx[3];
  assign exec = (state_r == ST_EXEC);
  assign exec_f = exec && (op == OP_FNEG_STORE);
  assign exec_i = exec && (op == OP_INEG);

  function automatic logic [DATA_W-1:0] disp_of(
    input logic [1:0] sel,
    input logic [DATA_W-1:0] ireg0,
    input logic [DATA_W-1:0] ireg1
  );
    case (sel)
      DISP_ZERO: disp_of = '0;
      DISP_ONE: disp_of = 32'h0000_0001;
      DISP_IREG0: disp_of = ireg0;
      default: disp_of = ireg1;
    endcase
  endfunction : disp_of

  // Indirect addresses: auxiliary register plus displacement
  assign ea1 = core_r[{IDX_AR_HI, instr_r[F_AR1 +: 2]}][DATA_W-1:0]
    + disp_of(instr_r[F_DSP1 +: 2], core_r[IDX_IREG0][DATA_W-1:0],
      core_r[IDX_IREG1][DATA_W-1:0]);
  assign ea2 = core_r[{IDX_AR_HI, instr_r[F_AR2 +: 2]}][DATA_W-1:0]
    + disp_of(instr_r[F_DSP2 +: 2], core_r[IDX_IREG0][DATA_W-1:0],
      core_r[IDX_IREG1][DATA_W-1:0]);

  // ----------------------------------------------------------------
  // Memory and negators
  // ----------------------------------------------------------------
  logic mem_we;
  logic [MEM_AW-1:0] mem_waddr;
  logic [DATA_W-1:0] mem_wdata;
  logic [MEM_AW-1:0] mem_raddr;
  logic [DATA_W-1:0] mem_rdata;
  logic [DATA_W-1:0] i_src;
  logic [EXP_W-1:0] f_res_exp;
  logic [DATA_W-1:0] f_res_man;
  logic f_ovf;
  logic f_unf;
  logic [DATA_W-1:0] i_res;
  logic i_ovf;
  logic i_borrow;
  logic wr_fire;
  logic [DATA_W-1:0] wr_val;

  // Operand fetched in the cycle before execute
  always_comb begin
    mem_raddr = mem_addr_r;
    if (state_r != ST_IDLE) begin
      mem_raddr = ea1[MEM_AW-1:0];
      if (op == OP_INEG && mode == MODE_DIRECT) begin
        mem_raddr = imm[MEM_AW-1:0];
      end
    end
  end

  // Store half takes the register as it stood before commit
  always_comb begin
    mem_we = 1'b0;
    mem_waddr = mem_addr_r;
    mem_wdata = wr_val;
    if (exec_f) begin
      mem_we = 1'b1;
      mem_waddr = ea2[MEM_AW-1:0];
      mem_wdata = {core_r[src3_idx][39:32], core_r[src3_idx][31:8]};
    end else if (wr_fire && awaddr_r == ADDR_MEM_DATA) begin
      mem_we = 1'b1;
    end
  end

  nps_mem #(.AW(MEM_AW), .DW(DATA_W)) u_mem (
    .clk(aclk),
    .we(mem_we),
    .waddr(mem_waddr),
    .wdata(mem_wdata),
    .raddr(mem_raddr),
    .rdata_r(mem_rdata)
  );

  always_comb begin
    case (mode)
      MODE_REG: i_src = core_r[imm[3:0]][DATA_W-1:0];
      MODE_IMM: i_src = {{16{imm[15]}}, imm};
      default: i_src = mem_rdata;
    endcase
  end

  // Saturation mode reaches only the integer path
  nps_neg u_neg (
    .f_exp(mem_rdata[31:24]),
    .f_man({mem_rdata[23:0], 8'h00}),
    .i_src(i_src),
    .sat_mode(sat_mode_r),
    .f_res_exp(f_res_exp),
    .f_res_man(f_res_man),
    .f_ovf(f_ovf),
    .f_unf(f_unf),
    .i_res(i_res),
    .i_ovf(i_ovf),
    .i_borrow(i_borrow)
  );

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_r <= ST_IDLE;
      instr_r <= '0;
    end else begin
      case (state_r)
        ST_IDLE: begin
          if (wr_fire && awaddr_r == ADDR_INSTR) begin
            instr_r <= wr_val;
            state_r <= ST_FETCH;
          end
        end
        ST_FETCH: state_r <= ST_EXEC;
        ST_EXEC: state_r <= ST_IDLE;
        default: state_r <= ST_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Core registers and flags
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int i = 0; i < CORE_N; i++) begin
        core_r[i] <= '0;
      end
    end else if (exec_f) begin
      core_r[dst_idx] <= {f_res_exp, f_res_man};
    end else if (exec_i) begin
      core_r[dst_idx][DATA_W-1:0] <= i_res;
    end else if (wr_fire && awaddr_r == ADDR_REG_LO) begin
      core_r[regsel_r][DATA_W-1:0] <= wr_val;
    end else if (wr_fire && awaddr_r == ADDR_REG_HI) begin
      core_r[regsel_r][39:32] <= wr_val[EXP_W-1:0];
    end
  end

  always_comb begin
    flags_nxt = flags_r;
    if (exec_f) begin
      flags_nxt.sticky_unf = flags_r.sticky_unf | f_unf;
      flags_nxt.sticky_ovf = flags_r.sticky_ovf | f_ovf;
      flags_nxt.unf = f_unf;
      flags_nxt.n = f_res_man[31];
      flags_nxt.z = (f_res_exp == EXP_ZERO);
      flags_nxt.v = f_ovf;
    end else begin
      flags_nxt.sticky_ovf = flags_r.sticky_ovf | i_ovf;
      flags_nxt.unf = 1'b0;
      flags_nxt.n = i_res[31];
      flags_nxt.z = (i_res == '0);
      flags_nxt.v = i_ovf;
      flags_nxt.c = i_borrow;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      flags_r <= FLAGS_RST;
    end else if ((exec_f || exec_i) && dst_is_ext) begin
      // No-op codes still run the sequence but must not touch flags
      flags_r <= flags_nxt;
    end else if (wr_fire && awaddr_r == ADDR_FLAGS) begin
      flags_r <= wr_val[6:0];
    end
  end

  // ----------------------------------------------------------------
  // AXI4-Lite write channel
  // ----------------------------------------------------------------
  logic wr_known;
  logic rd_take;
  logic [DATA_W-1:0] rd_val;
  logic rd_known;

  // Bus writes wait while an instruction runs, so they never collide
  assign wr_fire = !rsp_r.awready && !rsp_r.wready && !rsp_r.bvalid
    && (state_r == ST_IDLE);
  assign wr_known = (awaddr_r <= ADDR_IRQ_MASK) && (awaddr_r[1:0] == 2'h0);

  always_comb begin
    for (int b = 0; b < 4; b++) begin
      wr_val[b*8 +: 8] = wstrb_r[b] ? wdata_r[b*8 +: 8] : 8'h00;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rsp_r.awready <= 1'b1;
      rsp_r.wready <= 1'b1;
      rsp_r.bvalid <= 1'b0;
      rsp_r.bresp <= RESP_OKAY;
      rsp_r.arready <= 1'b1;
      rsp_r.rvalid <= 1'b0;
      rsp_r.rdata <= '0;
      rsp_r.rresp <= RESP_OKAY;
      awaddr_r <= '0;
      wdata_r <= '0;
      wstrb_r <= '0;
    end else begin
      if (s_axi_req.awvalid && rsp_r.awready) begin
        rsp_r.awready <= 1'b0;
        awaddr_r <= s_axi_req.awaddr;
      end
      if (s_axi_req.wvalid && rsp_r.wready) begin
        rsp_r.wready <= 1'b0;
        wdata_r <= s_axi_req.wdata;
        wstrb_r <= s_axi_req.wstrb;
      end
      if (wr_fire) begin
        rsp_r.bvalid <= 1'b1;
        rsp_r.bresp <= wr_known ? RESP_OKAY : RESP_SLVERR;
      end
      if (rsp_r.bvalid && s_axi_req.bready) begin
        rsp_r.bvalid <= 1'b0;
        rsp_r.awready <= 1'b1;
        rsp_r.wready <= 1'b1;
      end
      // Read side shares this process: one owner for the response struct
      if (rd_take) begin
        rsp_r.arready <= 1'b0;
        rsp_r.rvalid <= 1'b1;
        rsp_r.rdata <= rd_val;
        rsp_r.rresp <= rd_known ? RESP_OKAY : RESP_SLVERR;
      end else if (rsp_r.rvalid && s_axi_req.rready) begin
        rsp_r.rvalid <= 1'b0;
        rsp_r.arready <= 1'b1;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sat_mode_r <= 1'b0;
      regsel_r <= '0;
      mem_addr_r <= '0;
      irq_mask_r <= IRQ_MASK_RST;
    end else if (wr_fire) begin
      case (awaddr_r)
        ADDR_CTRL: sat_mode_r <= wr_val[0];
        ADDR_REG_SEL: regsel_r <= wr_val[3:0];
        ADDR_MEM_ADDR: mem_addr_r <= wr_val[MEM_AW-1:0];
        ADDR_IRQ_MASK: irq_mask_r <= wr_val[IRQ_W-1:0];
        default: ;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // AXI4-Lite read channel
  // ----------------------------------------------------------------
  assign rd_take = s_axi_req.arvalid && rsp_r.arready;

  always_comb begin
    rd_known = 1'b1;
    case (s_axi_req.araddr)
      ADDR_CTRL: rd_val = {31'h0000_0000, sat_mode_r};
      ADDR_INSTR: rd_val = instr_r;
      ADDR_FLAGS: rd_val = {23'h00_0000, state_r != ST_IDLE, 1'b0, flags_r};
      ADDR_REG_SEL: rd_val = {28'h000_0000, regsel_r};
      ADDR_REG_LO: rd_val = core_r[regsel_r][DATA_W-1:0];
      ADDR_REG_HI: rd_val = {24'h00_0000, core_r[regsel_r][39:32]};
      ADDR_MEM_ADDR: rd_val = {{(DATA_W-MEM_AW){1'b0}}, mem_addr_r};
      ADDR_MEM_DATA: rd_val = mem_rdata;
      ADDR_IRQ_STAT: rd_val = {29'h0000_0000, irq_stat_r};
      ADDR_IRQ_MASK: rd_val = {29'h0000_0000, irq_mask_r};
      default: begin
        rd_val = '0;
        rd_known = 1'b0;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // Interrupts
  // ----------------------------------------------------------------
  logic [IRQ_W-1:0] irq_set;
  logic [IRQ_W-1:0] irq_clr;

  assign irq_set[IRQ_DONE] = exec;
  assign irq_set[IRQ_OVF] = exec_f ? f_ovf : (exec_i && i_ovf);
  assign irq_set[IRQ_UNF] = exec_f && f_unf;
  assign irq_clr = (rd_take && s_axi_req.araddr == ADDR_IRQ_STAT) ? '1 : '0;

  // An event in the clearing cycle survives the read
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_stat_r <= '0;
      irq <= 1'b0;
    end else begin
      irq_stat_r <= (irq_stat_r & ~irq_clr) | irq_set;
      irq <= |(irq_stat_r & irq_mask_r);
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  AST_ONE_CYCLE_EXEC: assert property (
    state_r == ST_FETCH |=> exec ##1 state_r == ST_IDLE)
    else $error("execute did not last exactly one cycle");
  AST_FLAGS_HELD: assert property (
    exec && !dst_is_ext |=> flags_r == $past(flags_r))
    else $error("flags changed for a non-extended destination");
  AST_STICKY_UNF: assert property (
    exec_f && dst_is_ext |=> flags_r.sticky_unf == ($past(flags_r.sticky_unf) || $past(f_unf)))
    else $error("sticky underflow wrong after float negate");
  AST_STICKY_OVF: assert property (
    exec_f && dst_is_ext && f_ovf |=> flags_r.sticky_ovf && flags_r.v)
    else $error("float overflow not recorded");
  AST_UNF_FOLLOWS: assert property (
    exec_f && dst_is_ext |=> flags_r.unf == $past(f_unf))
    else $error("underflow flag does not follow float negate");
  AST_INT_NZ: assert property (
    exec_i && dst_is_ext |=> flags_r.z == (core_r[$past(dst_idx)][31:0] == '0)
      && flags_r.n == core_r[$past(dst_idx)][31])
    else $error("zero or negative flag disagrees with integer result");
  AST_CARRY_KEPT: assert property (
    exec_f |=> flags_r.c == $past(flags_r.c))
    else $error("float negate touched carry");
  AST_STORE_OLD: assert property (
    exec_f && src3_idx == dst_idx |-> mem_wdata[31:24] == core_r[dst_idx][39:32]
      ##1 core_r[$past(dst_idx)][39:32] == $past(f_res_exp))
    else $error("store did not use the pre-negation register");
  AST_INT_STICKY_UNF: assert property (
    exec_i |=> flags_r.sticky_unf == $past(flags_r.sticky_unf))
    else $error("integer negate changed sticky underflow");
  AST_INT_UNF_CLEAR: assert property (
    exec_i && dst_is_ext |=> !flags_r.unf && flags_r.v == ($past(i_src) == INT_MIN))
    else $error("integer underflow or overflow flag wrong");
  AST_BORROW: assert property (
    exec_i && dst_is_ext |=> flags_r.c == ($past(i_src) != '0))
    else $error("carry does not show the borrow");
  AST_SATURATE: assert property (
    exec_i && sat_mode_r && i_src == INT_MIN |=> core_r[$past(dst_idx)][31:0] == INT_POS_MAX)
    else $error("saturating mode did not clamp overflow");
  AST_WRAP: assert property (
    exec_i && !sat_mode_r && i_src == INT_MIN |=> core_r[$past(dst_idx)][31:0] == INT_MIN)
    else $error("wrapping mode did not wrap overflow");
endmodule : nps_top

// ### testbench.sv
// Self-checking testbench for the negate-and-store datapath
`timescale 1ns/1ns
module testbench;
  import nps_pkg::*;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  nps_axi_req_s req = '0;
  nps_axi_rsp_s rsp;
  logic irq;
  int errors = 0;
  int check_count = 0;
  logic [31:0] rd;
  logic [1:0] rr;
  always #50 aclk = ~aclk;
  nps_top #(.MEM_AW(8)) i_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_req(req),
    .s_axi_rsp(rsp), .irq(irq));
  // ----------------------------------------------------------------
  // Report and bus tasks
  // ----------------------------------------------------------------
  task automatic results();
    $display("errors %0d, checks %0d", errors, check_count);
    if (errors == 0 && check_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : results
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask : chk
  // Valid held until its own ready; response ready held until answer
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bit aw = 0;
    bit w = 0;
    bit b = 0;
    int n = 0;
    req.awvalid <= 1'b1;
    req.awaddr <= a;
    req.wvalid <= 1'b1;
    req.wdata <= d;
    req.wstrb <= 4'hF;
    req.bready <= 1'b1;
    while (!b && n < 50) begin
      @(posedge aclk);
      n++;
      if (!aw && rsp.awready) begin
        aw = 1;
        req.awvalid <= 1'b0;
      end
      if (!w && rsp.wready) begin
        w = 1;
        req.wvalid <= 1'b0;
      end
      b = rsp.bvalid;
      rr = rsp.bresp;
    end
    if (!b) begin
      errors++;
      results();
    end
  endtask : wr
  task automatic rdr(input logic [7:0] a);
    bit ar = 0;
    bit r = 0;
    int n = 0;
    req.arvalid <= 1'b1;
    req.araddr <= a;
    req.rready <= 1'b1;
    while (!r && n < 50) begin
      @(posedge aclk);
      n++;
      if (!ar && rsp.arready) begin
        ar = 1;
        req.arvalid <= 1'b0;
      end
      r = rsp.rvalid;
      rd = rsp.rdata;
      rr = rsp.rresp;
    end
    if (!r) begin
      errors++;
      results();
    end
  endtask : rdr
  task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
    rdr(a);
    chk(rd, exp);
    chk({30'h0, rr}, {30'h0, RESP_OKAY});
  endtask : rchk
  // Issue, then let fetch and execute finish
  task automatic exe(input logic [31:0] w);
    wr(ADDR_INSTR, w);
    repeat (4) @(posedge aclk);
  endtask : exe
  task automatic setr(input logic [7:0] a, input logic [31:0] i, input logic [31:0] d);
    wr(a - 8'h04, i);
    wr(a, d);
  endtask : setr
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    rchk(ADDR_FLAGS, 32'h0000_0000);
    rchk(ADDR_IRQ_MASK, 32'h0000_0000);
    wr(8'h30, 32'h0000_0001);
    chk({30'h0, rr}, {30'h0, RESP_SLVERR});
    rdr(8'h30);
    chk({30'h0, rr}, {30'h0, RESP_SLVERR});
    chk(rd, 32'h0000_0000);
  endtask : t_reset
  task automatic t_modes();
    logic [31:0] w[4] = '{32'h8600_0003, 32'h9600_0040, 32'hA612_0000, 32'hB600_00AE};
    logic [31:0] e[4] = '{32'hFFFF_FFF9, 32'hFFFF_FFFB, 32'hFFFF_FFF7, 32'hFFFF_FF52};
    setr(ADDR_REG_LO, 3, 32'h0000_0007);
    setr(ADDR_REG_LO, 10, 32'h0000_0040);
    setr(ADDR_MEM_DATA, 32'h40, 32'h0000_0005);
    setr(ADDR_MEM_DATA, 32'h41, 32'h0000_0009);
    wr(ADDR_IRQ_MASK, 32'h0000_0001);
    for (int i = 0; i < 4; i++) begin
      exe(w[i]);
      wr(ADDR_REG_SEL, 32'h0000_0006);
      rchk(ADDR_REG_LO, e[i]);
      rchk(ADDR_FLAGS, 32'h0000_0009);
    end
    chk({31'h0, irq}, 32'h0000_0001);
    rchk(ADDR_IRQ_STAT, 32'h0000_0001);
    repeat (2) @(posedge aclk);
    chk({31'h0, irq}, 32'h0000_0000);
    exe(32'h8600_0000);
    rchk(ADDR_FLAGS, 32'h0000_0004);
  endtask : t_modes
  // Most negative source: wraps or clamps by mode
  task automatic t_ovf();
    setr(ADDR_REG_LO, 3, 32'h8000_0000);
    for (int s = 0; s < 2; s++) begin
      wr(ADDR_CTRL, s);
      wr(ADDR_FLAGS, 32'h0000_0040);
      exe(32'h8400_0003);
      wr(ADDR_REG_SEL, 32'h0000_0004);
      rchk(ADDR_REG_LO, s ? INT_POS_MAX : INT_MIN);
      rchk(ADDR_FLAGS, s ? 32'h0000_0063 : 32'h0000_006B);
    end
  endtask : t_ovf
  task automatic t_nodst();
    wr(ADDR_FLAGS, 32'h0000_0041);
    exe(32'hB800_0001);
    rchk(ADDR_FLAGS, 32'h0000_0041);
    wr(ADDR_REG_SEL, 32'h0000_0008);
    rchk(ADDR_REG_LO, 32'hFFFF_FFFF);
  endtask : t_nodst
  // Store source equals negate destination: store must see old value
  task automatic t_float();
    wr(ADDR_CTRL, 32'h0000_0001);
    wr(ADDR_FLAGS, 32'h0000_0001);
    setr(ADDR_REG_LO, 2, 32'h33C0_0000);
    wr(ADDR_REG_HI, 32'h0000_0007);
    setr(ADDR_REG_LO, 8, 32'h0000_0010);
    setr(ADDR_REG_LO, 9, 32'h0000_0020);
    setr(ADDR_MEM_DATA, 32'h10, 32'h057B_4000);
    exe(32'h4240_A000);
    wr(ADDR_REG_SEL, 32'h0000_0002);
    rchk(ADDR_REG_HI, 32'h0000_0005);
    rchk(ADDR_REG_LO, 32'h84C0_0000);
    rchk(ADDR_FLAGS, 32'h0000_0009);
    wr(ADDR_MEM_ADDR, 32'h0000_0021);
    repeat (2) @(posedge aclk);
    rchk(ADDR_MEM_DATA, 32'h0733_C000);
    // Saturation off now: float overflow, then underflow
    wr(ADDR_CTRL, 32'h0000_0000);
    setr(ADDR_MEM_DATA, 32'h10, 32'h7F80_0000);
    exe(32'h4240_A000);
    rchk(ADDR_REG_HI, 32'h0000_007F);
    rchk(ADDR_REG_LO, 32'h7FFF_FFFF);
    rchk(ADDR_FLAGS, 32'h0000_0023);
    setr(ADDR_MEM_DATA, 32'h10, 32'h8100_0000);
    exe(32'h4240_A000);
    rchk(ADDR_FLAGS, 32'h0000_0075);
    rchk(ADDR_IRQ_STAT, 32'h0000_0007);
  endtask : t_float
  initial begin
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_reset();
    t_modes();
    t_ovf();
    t_nodst();
    t_float();
    results();
  end
endmodule : testbench
